// ### dtd_cfg.svh
// Constants of the data-transfer decode and timing block
`ifndef DTD_CFG_SVH
`define DTD_CFG_SVH
`define DTD_CLK_RM_ST 5'h02
`define DTD_CLK_RM_LD_R 5'h02
`define DTD_CLK_RM_LD_M 5'h04
`define DTD_CLK_IMM 5'h02
`define DTD_CLK_ACC_LD 5'h04
`define DTD_CLK_ACC_ST 5'h02
`define DTD_CLK_SEG_LD_R 5'h02
`define DTD_CLK_SEG_LD_M 5'h05
`define DTD_CLK_SEG_LD_PR 5'h12
`define DTD_CLK_SEG_LD_PM 5'h13
`define DTD_CLK_SEG_ST 5'h02
`define DTD_CLK_EXT_R 5'h03
`define DTD_CLK_EXT_M 5'h06
`define DTD_CLK_PUSH_RM 5'h05
`define DTD_CLK_PUSH_SEG 5'h02
`define DTD_CLK_POP_RM 5'h05
`define DTD_CLK_POP_SEG_R 5'h07
`define DTD_CLK_POP_SEG_P 5'h15
`define DTD_CLK_EA2 5'h01
`define DTD_OFF_CTRL 8'h00
`define DTD_OFF_STAT 8'h04
`define DTD_OFF_NDONE 8'h08
`define DTD_CTRL_EN_BIT 0
`define DTD_CTRL_RST 1'h1
`define DTD_STAT_FORM_LSB 0
`define DTD_STAT_BUSY_BIT 4
`define DTD_STAT_FAULT_BIT 5
`define DTD_STAT_CLK_LSB 8
`endif

// ### dtd_pkg.sv
// Types of the data-transfer decode and timing block
package dtd_pkg;
  typedef enum logic [3:0] {
    F_NONE = 4'h0,
    F_RM_ST = 4'h1,
    F_RM_LD = 4'h2,
    F_IMM_R = 4'h3,
    F_ACC_LD = 4'h4,
    F_ACC_ST = 4'h5,
    F_SEG_LD = 4'h6,
    F_SEG_ST = 4'h7,
    F_SX = 4'h8,
    F_ZX = 4'h9,
    F_PUSH_RM = 4'ha,
    F_PUSH_S2 = 4'hb,
    F_PUSH_S3 = 4'hc,
    F_POP_RM = 4'hd,
    F_POP_S2 = 4'he
  } dtd_form_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } dtd_state_e;
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
  } dtd_instr_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dtd_bus_s;
endpackage

// ### dtd_decode.sv
// Decode and execution timing of the general data-transfer instructions
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "dtd_cfg.svh"
module dtd_decode (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Instruction start
  input wire logic start_i,
  input wire dtd_pkg::dtd_instr_s instr_i,
  input wire logic pmode_i,
  // Execution stalls and abort
  input wire logic wait_i,
  input wire logic hold_i,
  input wire logic exc_i,
  // Register port
  input wire dtd_pkg::dtd_bus_s bus_i,
  output logic [31:0] rdata_o,
  // Execution status
  output logic busy_o,
  output logic done_o,
  output logic fault_o,
  output dtd_pkg::dtd_form_e form_o,
  output logic [4:0] clocks_o
);

  dtd_pkg::dtd_state_e state;
  dtd_pkg::dtd_form_e dec_form;
  logic [4:0] dec_clk;
  logic [4:0] cnt;
  logic en;
  logic [15:0] ndone;
  logic dec_mem;
  logic dec_ea2;
  logic accept;
  logic stall;
  logic finish;
  logic [7:0] modrm;
  logic [7:0] sib;

  // Two general registers in the address (32-bit form)
  function automatic logic ea_two(input logic [7:0] m, input logic [7:0] s);
    ea_two = (m[7:6] != 2'h3) && (m[2:0] == 3'h4) && (s[5:3] != 3'h4) &&
      !((m[7:6] == 2'h0) && (s[2:0] == 3'h5));
  endfunction

  // Form decode
  always_comb begin
    dec_form = dtd_pkg::F_NONE;
    modrm = instr_i.b1;
    sib = instr_i.b2;
    if (instr_i.b0[7:1] == 7'h44) begin
      dec_form = dtd_pkg::F_RM_ST;
    end else if (instr_i.b0[7:1] == 7'h45) begin
      dec_form = dtd_pkg::F_RM_LD;
    end else if (instr_i.b0[7:4] == 4'hb) begin
      dec_form = dtd_pkg::F_IMM_R;
    end else if (instr_i.b0[7:1] == 7'h50) begin
      dec_form = dtd_pkg::F_ACC_LD;
    end else if (instr_i.b0[7:1] == 7'h51) begin
      dec_form = dtd_pkg::F_ACC_ST;
    end else if (instr_i.b0 == 8'h8e) begin
      dec_form = dtd_pkg::F_SEG_LD;
    end else if (instr_i.b0 == 8'h8c) begin
      dec_form = dtd_pkg::F_SEG_ST;
    end else if (instr_i.b0 == 8'hff && instr_i.b1[5:3] == 3'h6) begin
      dec_form = dtd_pkg::F_PUSH_RM;
    end else if (instr_i.b0[7:5] == 3'h0 && instr_i.b0[2:0] == 3'h6) begin
      dec_form = dtd_pkg::F_PUSH_S2;
    end else if (instr_i.b0 == 8'h8f && instr_i.b1[5:3] == 3'h0) begin
      dec_form = dtd_pkg::F_POP_RM;
    end else if (instr_i.b0[7:5] == 3'h0 && instr_i.b0[2:0] == 3'h7 &&
                 instr_i.b0[4:3] != 2'h1) begin
      dec_form = dtd_pkg::F_POP_S2;
    end else if (instr_i.b0 == 8'h0f) begin
      modrm = instr_i.b2;
      sib = instr_i.b3;
      if (instr_i.b1[7:1] == 7'h5f) begin
        dec_form = dtd_pkg::F_SX;
      end else if (instr_i.b1[7:1] == 7'h5b) begin
        dec_form = dtd_pkg::F_ZX;
      end else if (instr_i.b1[7:6] == 2'h2 && instr_i.b1[2:0] == 3'h0 &&
                   instr_i.b1[5:4] == 2'h2) begin
        dec_form = dtd_pkg::F_PUSH_S3;
      end
    end
  end

  // Operand kind and address cost
  always_comb begin
    dec_mem = modrm[7:6] != 2'h3;
    dec_ea2 = 1'b0;
    case (dec_form)
      dtd_pkg::F_RM_ST, dtd_pkg::F_RM_LD, dtd_pkg::F_SEG_LD, dtd_pkg::F_SEG_ST,
      dtd_pkg::F_SX, dtd_pkg::F_ZX, dtd_pkg::F_PUSH_RM, dtd_pkg::F_POP_RM: begin
        dec_ea2 = ea_two(modrm, sib);
      end
      default: begin
        dec_ea2 = 1'b0;
      end
    endcase
  end

  // Base clock count by form, operand kind and mode
  always_comb begin
    case (dec_form)
      dtd_pkg::F_RM_ST: dec_clk = `DTD_CLK_RM_ST;
      dtd_pkg::F_RM_LD: dec_clk = dec_mem ? `DTD_CLK_RM_LD_M : `DTD_CLK_RM_LD_R;
      dtd_pkg::F_IMM_R: dec_clk = `DTD_CLK_IMM;
      dtd_pkg::F_ACC_LD: dec_clk = `DTD_CLK_ACC_LD;
      dtd_pkg::F_ACC_ST: dec_clk = `DTD_CLK_ACC_ST;
      dtd_pkg::F_SEG_LD: begin
        if (pmode_i) begin
          dec_clk = dec_mem ? `DTD_CLK_SEG_LD_PM : `DTD_CLK_SEG_LD_PR;
        end else begin
          dec_clk = dec_mem ? `DTD_CLK_SEG_LD_M : `DTD_CLK_SEG_LD_R;
        end
      end
      dtd_pkg::F_SEG_ST: dec_clk = `DTD_CLK_SEG_ST;
      dtd_pkg::F_SX, dtd_pkg::F_ZX: dec_clk = dec_mem ? `DTD_CLK_EXT_M : `DTD_CLK_EXT_R;
      dtd_pkg::F_PUSH_RM: dec_clk = `DTD_CLK_PUSH_RM;
      dtd_pkg::F_PUSH_S2, dtd_pkg::F_PUSH_S3: dec_clk = `DTD_CLK_PUSH_SEG;
      dtd_pkg::F_POP_RM: dec_clk = `DTD_CLK_POP_RM;
      dtd_pkg::F_POP_S2: dec_clk = pmode_i ? `DTD_CLK_POP_SEG_P : `DTD_CLK_POP_SEG_R;
      default: dec_clk = 5'h00;
    endcase
  end

  assign accept = (state == dtd_pkg::ST_IDLE) && start_i && en &&
    (dec_form != dtd_pkg::F_NONE);
  assign stall = wait_i || hold_i;
  assign finish = (state == dtd_pkg::ST_EXEC) && !stall && !exc_i && (cnt == 5'h00);

  // Sequencer
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= dtd_pkg::ST_IDLE;
    end else begin
      case (state)
        dtd_pkg::ST_IDLE: begin
          if (accept) begin
            state <= dtd_pkg::ST_EXEC;
          end
        end
        dtd_pkg::ST_EXEC: begin
          if (finish || exc_i) begin
            state <= dtd_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= dtd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Clock counter, held by wait states and hold
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 5'h00;
    end else if (accept) begin
      cnt <= dec_clk + (dec_ea2 ? `DTD_CLK_EA2 : 5'h00) - 5'h01;
    end else if (state == dtd_pkg::ST_EXEC && !stall && cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
  end

  // Status outputs
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      fault_o <= 1'b0;
      form_o <= dtd_pkg::F_NONE;
      clocks_o <= 5'h00;
    end else begin
      done_o <= finish;
      fault_o <= ((state == dtd_pkg::ST_EXEC) && exc_i) ||
        ((state == dtd_pkg::ST_IDLE) && start_i && en && (dec_form == dtd_pkg::F_NONE));
      if (accept) begin
        busy_o <= 1'b1;
        form_o <= dec_form;
        clocks_o <= dec_clk + (dec_ea2 ? `DTD_CLK_EA2 : 5'h00);
      end else if (finish || ((state == dtd_pkg::ST_EXEC) && exc_i)) begin
        busy_o <= 1'b0;
      end
    end
  end

  // Control register and completion count
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en <= `DTD_CTRL_RST;
    end else if (bus_i.wr && bus_i.addr == `DTD_OFF_CTRL) begin
      en <= bus_i.wdata[`DTD_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ndone <= 16'h0000;
    end else if (finish) begin
      ndone <= ndone + 16'h0001;
    end else if (bus_i.wr && bus_i.addr == `DTD_OFF_NDONE) begin
      ndone <= 16'h0000;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h00000000;
    end else if (bus_i.rd) begin
      rdata_o <= 32'h00000000;
      case (bus_i.addr)
        `DTD_OFF_CTRL: rdata_o[`DTD_CTRL_EN_BIT] <= en;
        `DTD_OFF_STAT: begin
          rdata_o[`DTD_STAT_FORM_LSB +: 4] <= form_o;
          rdata_o[`DTD_STAT_BUSY_BIT] <= busy_o;
          rdata_o[`DTD_STAT_FAULT_BIT] <= fault_o;
          rdata_o[`DTD_STAT_CLK_LSB +: 5] <= clocks_o;
        end
        `DTD_OFF_NDONE: rdata_o[15:0] <= ndone;
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  // Checking helpers
  logic [4:0] run_cyc;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_cyc <= 5'h00;
    end else if (accept) begin
      run_cyc <= 5'h00;
    end else if (state == dtd_pkg::ST_EXEC && !stall) begin
      run_cyc <= run_cyc + 5'h01;
    end
  end

  logic acc_reg;
  assign acc_reg = accept && !dec_mem && !dec_ea2;

  a_rm_store_cnt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0[7:1] == 7'h44 && !dec_ea2 |=> clocks_o == 5'h02)
    else $error("register store count wrong");
  a_rm_load_cnt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0[7:1] == 7'h45 && !dec_ea2 |=>
    clocks_o == ($past(dec_mem) ? 5'h04 : 5'h02))
    else $error("register load count wrong");
  a_imm_load_cnt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0[7:4] == 4'hb |=> clocks_o == 5'h02 && form_o == dtd_pkg::F_IMM_R)
    else $error("immediate load count wrong");
  a_acc_moves: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0[7:2] == 6'h28 |=> clocks_o == (form_o == dtd_pkg::F_ACC_LD ?
    5'h04 : 5'h02))
    else $error("accumulator move count wrong");
  a_seg_load_prot: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    acc_reg && instr_i.b0 == 8'h8e && pmode_i |=> clocks_o == 5'h12)
    else $error("protected segment load count wrong");
  a_widen_mem: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0 == 8'h0f && dec_mem && !dec_ea2 &&
    (dec_form == dtd_pkg::F_SX || dec_form == dtd_pkg::F_ZX) |=> clocks_o == 5'h06)
    else $error("widening load count wrong");
  a_pop_seg_mode: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && dec_form == dtd_pkg::F_POP_S2 |=>
    clocks_o == ($past(pmode_i) ? 5'h15 : 5'h07))
    else $error("segment pop count wrong");
  a_ea_two_regs: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && dec_ea2 |=> clocks_o == $past(dec_clk) + 5'h01)
    else $error("address penalty missing");
  a_wait_extends: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    busy_o && !done_o && stall && !exc_i |=> !done_o && $stable(cnt))
    else $error("wait state not counted");
  a_done_timing: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    done_o |-> run_cyc == clocks_o)
    else $error("run length differs from count");
  a_short_push: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && !stall && !exc_i && dec_form == dtd_pkg::F_PUSH_S2 ##1 (!stall && !exc_i)
    ##1 (!stall && !exc_i) |=> done_o)
    else $error("segment push not done in two clocks");
  a_rm_store_ea2: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0[7:1] == 7'h44 && dec_ea2 |=> clocks_o == 5'h03)
    else $error("register store address penalty wrong");
  a_acc_store: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0[7:1] == 7'h51 |=>
    clocks_o == 5'h02 && form_o == dtd_pkg::F_ACC_ST)
    else $error("accumulator store count wrong");
  a_seg_load_real: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && dec_form == dtd_pkg::F_SEG_LD && !pmode_i && !dec_ea2 |=>
    clocks_o == ($past(dec_mem) ? 5'h05 : 5'h02))
    else $error("real mode segment load count wrong");
  a_seg_load_pmem: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && dec_form == dtd_pkg::F_SEG_LD && pmode_i && dec_mem && !dec_ea2 |=>
    clocks_o == 5'h13)
    else $error("protected memory segment load count wrong");
  a_seg_store_cnt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0 == 8'h8c && !dec_ea2 |=>
    clocks_o == 5'h02 && form_o == dtd_pkg::F_SEG_ST)
    else $error("segment store count wrong");
  a_widen_reg: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0 == 8'h0f && !dec_mem &&
    (dec_form == dtd_pkg::F_SX || dec_form == dtd_pkg::F_ZX) |=> clocks_o == 5'h03)
    else $error("widening register count wrong");
  a_push_rm_cnt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0 == 8'hff && instr_i.b1[5:3] == 3'h6 && !dec_ea2 |=>
    clocks_o == 5'h05 && form_o == dtd_pkg::F_PUSH_RM)
    else $error("operand push count wrong");
  a_push_seg2_cnt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && dec_form == dtd_pkg::F_PUSH_S2 |=> clocks_o == 5'h02)
    else $error("original segment push count wrong");
  a_push_seg3_cnt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0 == 8'h0f && (instr_i.b1 == 8'ha0 || instr_i.b1 == 8'ha8) |=>
    clocks_o == 5'h02 && form_o == dtd_pkg::F_PUSH_S3)
    else $error("added segment push count wrong");
  a_pop_rm_cnt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && instr_i.b0 == 8'h8f && instr_i.b1[5:3] == 3'h0 && !dec_ea2 |=>
    clocks_o == 5'h05 && form_o == dtd_pkg::F_POP_RM)
    else $error("operand pop count wrong");
  a_pop_seg_form: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && (instr_i.b0 == 8'h07 || instr_i.b0 == 8'h17 || instr_i.b0 == 8'h1f) |=>
    form_o == dtd_pkg::F_POP_S2)
    else $error("segment pop not decoded");
  a_ea_one_reg: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && !dec_ea2 |=> clocks_o == $past(dec_clk))
    else $error("address penalty added wrongly");
  a_cnt_step: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    busy_o && !stall && cnt != 5'h00 |=>
    cnt == $past(cnt) - 5'h01)
    else $error("clock counter did not advance");
  a_hold_extends: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    busy_o && hold_i && !exc_i |=> !done_o && $stable(cnt))
    else $error("bus hold not counted");
  a_form_held: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    busy_o |=> $stable(form_o) && $stable(clocks_o))
    else $error("form or count changed while busy");
  a_done_pulse: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    done_o |->
    !busy_o ##1 !done_o)
    else $error("completion pulse malformed");
  a_abort_fault: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    busy_o && exc_i |=> fault_o && !busy_o && !done_o)
    else $error("exception did not abort");

  c_seg_load: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && dec_form == dtd_pkg::F_SEG_LD && pmode_i ##[1:40] done_o);
  c_wait_run: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    busy_o && wait_i ##[1:20] done_o);
  c_abort: cover property (@(posedge mclk_i) disable iff (!nrst_i) busy_o && exc_i);
  c_ea2: cover property (@(posedge mclk_i) disable iff (!nrst_i) accept && dec_ea2);
  c_push_seg3: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    accept && dec_form == dtd_pkg::F_PUSH_S3 ##3 done_o);

endmodule

// ### tb_data_transfer_decode_timing.sv
// Self-checking testbench of the data-transfer decode and timing block
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
  end \
end
module tb_data_transfer_decode_timing;
  logic mclk_i;
  logic nrst_i;
  logic start_i;
  dtd_pkg::dtd_instr_s instr_i;
  logic pmode_i;
  logic wait_i;
  logic hold_i;
  logic exc_i;
  dtd_pkg::dtd_bus_s bus_i;
  logic [31:0] rdata_o;
  logic busy_o;
  logic done_o;
  logic fault_o;
  dtd_pkg::dtd_form_e form_o;
  logic [4:0] clocks_o;
  int n_fail = 0;
  int n_checks = 0;
  int n_done = 0;

  dtd_decode dut_u (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .start_i(start_i), .instr_i(instr_i),
    .pmode_i(pmode_i), .wait_i(wait_i), .hold_i(hold_i), .exc_i(exc_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .busy_o(busy_o), .done_o(done_o),
    .fault_o(fault_o), .form_o(form_o), .clocks_o(clocks_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Wait for completion, counting cycles since acceptance
  task automatic wdone(inout int n);
    while (done_o !== 1'b1 && n < 60) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    n_done++;
  endtask

  // One instruction with no stall; mode input flips after acceptance
  task automatic run(input logic [31:0] ins, input logic pm, input logic [3:0] fm,
                     input logic [4:0] ck);
    int n;
    @(posedge mclk_i);
    start_i <= 1'b1;
    instr_i <= ins;
    pmode_i <= pm;
    @(posedge mclk_i);
    start_i <= 1'b0;
    pmode_i <= ~pm;
    #1;
    n = 1;
    `CHK("form", form_o, fm)
    `CHK("clocks", clocks_o, ck)
    wdone(n);
    `CHK("latency", n, ck + 1)
    `CHK("busy at done", busy_o, 1'b0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus_i <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_i <= '0;
    #1;
    d = rdata_o;
  endtask

  task automatic t_moves;
    run(32'h88c00000, 1'b0, 4'h1, 5'h02);
    run(32'h89000000, 1'b1, 4'h1, 5'h02);
    run(32'h8ac00000, 1'b0, 4'h2, 5'h02);
    run(32'h8b000000, 1'b0, 4'h2, 5'h04);
    run(32'hb0000000, 1'b0, 4'h3, 5'h02);
    run(32'hbf000000, 1'b1, 4'h3, 5'h02);
    run(32'ha0000000, 1'b0, 4'h4, 5'h04);
    run(32'ha1000000, 1'b1, 4'h4, 5'h04);
    run(32'ha2000000, 1'b0, 4'h5, 5'h02);
    run(32'ha3000000, 1'b0, 4'h5, 5'h02);
    $display("test moves done");
  endtask

  task automatic t_seg;
    run(32'h8ed80000, 1'b0, 4'h6, 5'h02);
    run(32'h8e180000, 1'b0, 4'h6, 5'h05);
    run(32'h8ed80000, 1'b1, 4'h6, 5'h12);
    run(32'h8e180000, 1'b1, 4'h6, 5'h13);
    run(32'h8cd80000, 1'b1, 4'h7, 5'h02);
    run(32'h8c180000, 1'b0, 4'h7, 5'h02);
    run(32'h06000000, 1'b0, 4'hb, 5'h02);
    run(32'h1e000000, 1'b1, 4'hb, 5'h02);
    run(32'h0fa00000, 1'b0, 4'hc, 5'h02);
    run(32'h0fa80000, 1'b1, 4'hc, 5'h02);
    run(32'h07000000, 1'b0, 4'he, 5'h07);
    run(32'h17000000, 1'b1, 4'he, 5'h15);
    run(32'h1f000000, 1'b0, 4'he, 5'h07);
    $display("test segment done");
  endtask

  task automatic t_ext;
    run(32'h0fbec000, 1'b0, 4'h8, 5'h03);
    run(32'h0fbf0000, 1'b1, 4'h8, 5'h06);
    run(32'h0fb6c000, 1'b0, 4'h9, 5'h03);
    run(32'h0fb70000, 1'b0, 4'h9, 5'h06);
    run(32'hfff00000, 1'b1, 4'ha, 5'h05);
    run(32'hff300000, 1'b0, 4'ha, 5'h05);
    run(32'h8fc00000, 1'b0, 4'hd, 5'h05);
    run(32'h8f000000, 1'b1, 4'hd, 5'h05);
    $display("test widen and stack done");
  endtask

  task automatic t_ea;
    run(32'h8b040800, 1'b0, 4'h2, 5'h05);
    run(32'h8b440810, 1'b0, 4'h2, 5'h05);
    run(32'h8b042000, 1'b0, 4'h2, 5'h04);
    run(32'h8b040d00, 1'b0, 4'h2, 5'h04);
    run(32'h0fbe0408, 1'b0, 4'h8, 5'h07);
    $display("test address penalty done");
  endtask

  task automatic t_stall;
    int n;
    @(posedge mclk_i);
    start_i <= 1'b1;
    instr_i <= 32'h8b000000;
    pmode_i <= 1'b0;
    @(posedge mclk_i);
    start_i <= 1'b0;
    wait_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    wait_i <= 1'b0;
    hold_i <= 1'b1;
    @(posedge mclk_i);
    hold_i <= 1'b0;
    #1;
    n = 4;
    wdone(n);
    `CHK("stall latency", n, 8)
    @(posedge mclk_i);
    start_i <= 1'b1;
    @(posedge mclk_i);
    start_i <= 1'b0;
    exc_i <= 1'b1;
    @(posedge mclk_i);
    exc_i <= 1'b0;
    #1;
    `CHK("abort fault", fault_o, 1'b1)
    `CHK("abort busy", busy_o, 1'b0)
    @(posedge mclk_i);
    start_i <= 1'b1;
    instr_i <= 32'hc6000000;
    @(posedge mclk_i);
    start_i <= 1'b0;
    #1;
    `CHK("undecodable fault", fault_o, 1'b1)
    `CHK("undecodable busy", busy_o, 1'b0)
    $display("test stall and abort done");
  endtask

  task automatic t_regs;
    logic [31:0] d;
    rd(8'h00, d);
    `CHK("ctrl reset", d, 32'h1)
    rd(8'h04, d);
    `CHK("status", d, 32'h00000402)
    rd(8'h0c, d);
    `CHK("unmapped", d, 32'h0)
    rd(8'h08, d);
    `CHK("completions", d[15:0], n_done[15:0])
    wr(8'h08, 32'h0);
    rd(8'h08, d);
    `CHK("completions clear", d[15:0], 16'h0)
    wr(8'h00, 32'h0);
    @(posedge mclk_i);
    start_i <= 1'b1;
    instr_i <= 32'h89c00000;
    @(posedge mclk_i);
    start_i <= 1'b0;
    #1;
    `CHK("disabled busy", busy_o, 1'b0)
    wr(8'h00, 32'h1);
    $display("test registers done");
  endtask

  initial begin
    #(25 * 4000);
    n_fail++;
    test_done();
  end

  initial begin
    nrst_i = 1'b0;
    start_i = 1'b0;
    instr_i = '0;
    pmode_i = 1'b0;
    wait_i = 1'b0;
    hold_i = 1'b0;
    exc_i = 1'b0;
    bus_i = '0;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_moves();
    t_seg();
    t_ext();
    t_ea();
    t_stall();
    t_regs();
    test_done();
  end
endmodule
